/* File: rtl/hcn_pkg.sv */
// package for the handshake capability negotiation block
`default_nettype none
package hcn_pkg;
    // register byte offsets
    localparam logic [7:0] HCN_CTRL_OFS = 8'h00;
    localparam logic [7:0] HCN_LCAP_OFS = 8'h04;
    localparam logic [7:0] HCN_LVAL_OFS = 8'h08;
    localparam logic [7:0] HCN_RCAP_OFS = 8'h0C;
    localparam logic [7:0] HCN_RVAL_OFS = 8'h10;
    localparam logic [7:0] HCN_CL_OFS = 8'h14;
    localparam logic [7:0] HCN_MS_OFS = 8'h18;
    localparam logic [7:0] HCN_MSV_OFS = 8'h1C;
    localparam logic [7:0] HCN_STAT_OFS = 8'h20;
    // ctrl bits (write one, self clearing; USPREF is a level kept until the next control write)
    localparam int HCN_C_RESET = 0;
    localparam int HCN_C_LOS = 1;
    localparam int HCN_C_ERR = 2;
    localparam int HCN_C_NET = 3;
    localparam int HCN_C_START = 4;
    localparam int HCN_C_CLSENT = 5;
    localparam int HCN_C_CLRRX = 6;
    localparam int HCN_C_SEL = 7;
    localparam int HCN_C_DONE = 8;
    localparam int HCN_C_USPREF = 9;
    // capability field positions (level 1 and level 2 bits)
    localparam int HCN_B_MODE = 0;
    localparam int HCN_B_USOPT = 1;
    localparam int HCN_B_DSOPT = 2;
    localparam int HCN_B_EOC = 3;
    localparam int HCN_B_USBND = 4;
    localparam int HCN_B_DSBND = 5;
    localparam int HCN_B_XFORM = 6;
    localparam int HCN_B_CE = 7;
    localparam int HCN_B_RFI = 8;
    localparam int HCN_CAPW = 9;
    // value fields: transform size [3:0], initial ce length [15:8]
    localparam int HCN_V_XF_LO = 0;
    localparam int HCN_V_XF_W = 4;
    localparam int HCN_V_CE_LO = 8;
    localparam int HCN_V_CE_W = 8;
    localparam logic [HCN_CAPW-1:0] HCN_CAP_RST = 9'h000;
    localparam logic [31:0] HCN_ZERO = 32'h0000_0000;
    localparam logic [31:0] HCN_BAD = 32'hDEAD_0BAD;
    typedef enum logic [2:0] {
        HCN_SILENT1 = 3'b000,
        HCN_INITRST = 3'b001,
        HCN_HSHAKE = 3'b010,
        HCN_QUIET = 3'b011,
        HCN_OTHER = 3'b100
    } hcn_state_e;
endpackage
`default_nettype wire

/* File: rtl/hcn_top.sv */
// handshake capability negotiation, central side, with apb registers
//
// Function
// R1: send transform size, ce length, optional band
// R2: powerup, los, error enter silent state
// R3: network order: init reset, then handshake
// R4: selected mode concludes into quiet state
// R5: cl sets level one mode bit
// R6: every set spar2 bit carries npar3
// R7: cl band bits only if capable
// R8: cl eoc bit only if oam capable
// R9: used band lists exclude optional band
// R10: cl transform bit always one, max size
// R11: cl ce bit zero means mandatory only
// R12: mandatory ce if either supports only it
// R13: cl rfi bit optional, list follows
// R14: ms sets level one mode bit (code sets it only when both stored cl and clr mode bits are set)
// R15: both bands common: pick exactly one
// R16: no common band: clear both bits
// R17: ms band bit needs cl and clr
// R18: ms eoc bit needs cl and clr
// R19: ms used bands and rfi zero
// R20: ms transform one, common max size
// R21: ms ce one only if both one
// R22: keep last cl and clr capabilities
// R23: clear stored caps on silent entry
//
// register map, one aligned word each
// 0x00 control, write-one pulses, reads zero:
//   b0 power-up, b1 loss of signal, b2 init error: back to silent
//   b3 network order to init reset, b4 start handshake
//   b5 cl sent, b6 clr received, b7 build ms, b8 handshake done
//   b9 upstream preference level, reloaded from pwdata on every control write
// 0x04 local caps, 0x08 local values
// 0x0C received caps, 0x10 received values (written by the framer)
// 0x14 stored cl, 0x18 ms bits, 0x1C ms values, 0x20 state
// cap bits: b0 mode, b1 us band, b2 ds band, b3 eoc, b4 used us,
//   b5 used ds, b6 transform, b7 ce, b8 rfi
// values: [3:0] transform size code, [15:8] initial ce length
// silent events win over any other event in the same write
// no framing here: the framer deposits clr contents and sends
//   what the cl and ms registers hold
`default_nettype none
module hcn_top
    import hcn_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] hs_state,
    output logic mode_quiet
);

    // =====================================================
    // bus decode
    // =====================================================
    logic acc;
    logic wr;
    logic hit;
    assign acc = psel & penable;
    assign wr = acc & pwrite;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == HCN_CTRL_OFS) || (a == HCN_LCAP_OFS) || (a == HCN_LVAL_OFS) ||
            (a == HCN_RCAP_OFS) || (a == HCN_RVAL_OFS) || (a == HCN_CL_OFS) ||
            (a == HCN_MS_OFS) || (a == HCN_MSV_OFS) || (a == HCN_STAT_OFS);
    endfunction

    function automatic logic [HCN_V_XF_W-1:0] min_xf(input logic [HCN_V_XF_W-1:0] a,
                                                      input logic [HCN_V_XF_W-1:0] b);
        min_xf = (a < b) ? a : b;
    endfunction

    assign hit = is_mapped(paddr);

    logic ctl_wr;
    assign ctl_wr = wr && (paddr == HCN_CTRL_OFS);
    function automatic logic cbit(input logic en, input logic [31:0] d, input int n);
        cbit = en & d[n];
    endfunction

    // =====================================================
    // control events, one-cycle pulses from control writes
    // =====================================================
    logic go_silent;
    logic go_net;
    logic go_start;
    logic ev_clsent;
    logic ev_clrrx;
    logic ev_sel;
    logic ev_done;
    assign go_silent = cbit(ctl_wr, pwdata, HCN_C_RESET) | cbit(ctl_wr, pwdata, HCN_C_LOS) |
        cbit(ctl_wr, pwdata, HCN_C_ERR); // R2
    assign go_net = cbit(ctl_wr, pwdata, HCN_C_NET);
    assign go_start = cbit(ctl_wr, pwdata, HCN_C_START);
    assign ev_clsent = cbit(ctl_wr, pwdata, HCN_C_CLSENT);
    assign ev_clrrx = cbit(ctl_wr, pwdata, HCN_C_CLRRX);
    assign ev_sel = cbit(ctl_wr, pwdata, HCN_C_SEL);
    assign ev_done = cbit(ctl_wr, pwdata, HCN_C_DONE);

    // =====================================================
    // local capability configuration
    // =====================================================
    logic [HCN_CAPW-1:0] lcap_q;
    logic [31:0] lval_q;
    logic [HCN_CAPW-1:0] rcap_q;
    logic [31:0] rval_q;
    logic us_pref_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lcap_q <= HCN_CAP_RST;
        end else if (wr && paddr == HCN_LCAP_OFS) begin
            lcap_q <= pwdata[HCN_CAPW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lval_q <= HCN_ZERO;
        end else if (wr && paddr == HCN_LVAL_OFS) begin
            lval_q <= pwdata;
        end
    end

    // remote clr contents are deposited by the handshake framer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcap_q <= HCN_CAP_RST;
        end else if (wr && paddr == HCN_RCAP_OFS) begin
            rcap_q <= pwdata[HCN_CAPW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rval_q <= HCN_ZERO;
        end else if (wr && paddr == HCN_RVAL_OFS) begin
            rval_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_pref_q <= 1'b0;
        end else if (ctl_wr) begin
            us_pref_q <= pwdata[HCN_C_USPREF];
        end
    end

    // =====================================================
    // cl message build
    // =====================================================
    logic [HCN_CAPW-1:0] cl_bits;
    always_comb begin
        cl_bits = lcap_q;
        cl_bits[HCN_B_MODE] = 1'b1; // R5
        cl_bits[HCN_B_XFORM] = 1'b1; // R10 R1
        // band and eoc flags come only from capability config
        cl_bits[HCN_B_USOPT] = lcap_q[HCN_B_USOPT]; // R7
        cl_bits[HCN_B_DSOPT] = lcap_q[HCN_B_DSOPT]; // R7
        cl_bits[HCN_B_EOC] = lcap_q[HCN_B_EOC]; // R8
        // used-band and rfi lists are held by the framer; flags optional
        cl_bits[HCN_B_USBND] = lcap_q[HCN_B_USBND]; // R9 R13
        cl_bits[HCN_B_DSBND] = lcap_q[HCN_B_DSBND]; // R9
        cl_bits[HCN_B_RFI] = lcap_q[HCN_B_RFI]; // R13
        cl_bits[HCN_B_CE] = lcap_q[HCN_B_CE]; // R11
    end

    // =====================================================
    // handshake state
    // =====================================================
    hcn_state_e st_q;
    logic [HCN_CAPW-1:0] ms_q;
    logic [31:0] msv_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= HCN_SILENT1; // R2
        end else if (go_silent) begin
            st_q <= HCN_SILENT1; // R2
        end else begin
            unique case (st_q)
                HCN_SILENT1: begin
                    if (go_net) st_q <= HCN_INITRST; // R3
                    else if (go_start) st_q <= HCN_HSHAKE; // R3
                end
                HCN_INITRST: begin
                    if (go_start) st_q <= HCN_HSHAKE; // R3
                end
                HCN_HSHAKE: begin
                    if (ev_done) st_q <= ms_q[HCN_B_MODE] ? HCN_QUIET : HCN_OTHER; // R4
                end
                HCN_QUIET: begin
                end
                HCN_OTHER: begin
                end
                default: st_q <= HCN_SILENT1;
            endcase
        end
    end

    // =====================================================
    // stored cl and clr, ms derivation
    // =====================================================
    logic [HCN_CAPW-1:0] scl_q;
    logic [31:0] sclv_q;
    logic [HCN_CAPW-1:0] sclr_q;
    logic [31:0] sclrv_q;
    logic [HCN_CAPW-1:0] ms_d;
    logic [31:0] msv_d;
    logic in_hs;
    assign in_hs = (st_q == HCN_HSHAKE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= HCN_CAP_RST;
            sclv_q <= HCN_ZERO;
        end else if (go_silent) begin
            scl_q <= HCN_CAP_RST; // R23
            sclv_q <= HCN_ZERO; // R23
        end else if (in_hs && ev_clsent) begin
            scl_q <= cl_bits; // R22
            sclv_q <= lval_q; // R22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclr_q <= HCN_CAP_RST;
            sclrv_q <= HCN_ZERO;
        end else if (go_silent) begin
            sclr_q <= HCN_CAP_RST; // R23
            sclrv_q <= HCN_ZERO; // R23
        end else if (in_hs && ev_clrrx) begin
            sclr_q <= rcap_q; // R22
            sclrv_q <= rval_q; // R22
        end
    end

    logic both_us;
    logic both_ds;
    logic both_ce;
    always_comb begin
        both_us = scl_q[HCN_B_USOPT] & sclr_q[HCN_B_USOPT]; // R17
        both_ds = scl_q[HCN_B_DSOPT] & sclr_q[HCN_B_DSOPT]; // R17
        both_ce = scl_q[HCN_B_CE] & sclr_q[HCN_B_CE]; // R21 R12
        ms_d = HCN_CAP_RST; // R19 R16
        ms_d[HCN_B_MODE] = scl_q[HCN_B_MODE] & sclr_q[HCN_B_MODE]; // R14
        // with both directions common only one survives, steered by preference
        if (both_us && both_ds) begin
            ms_d[HCN_B_USOPT] = us_pref_q; // R15
            ms_d[HCN_B_DSOPT] = ~us_pref_q; // R15
        end else begin
            ms_d[HCN_B_USOPT] = both_us; // R17
            ms_d[HCN_B_DSOPT] = both_ds; // R17
        end
        ms_d[HCN_B_EOC] = scl_q[HCN_B_EOC] & sclr_q[HCN_B_EOC]; // R18
        ms_d[HCN_B_XFORM] = 1'b1; // R20
        ms_d[HCN_B_CE] = both_ce; // R21
        msv_d = HCN_ZERO;
        msv_d[HCN_V_XF_LO +: HCN_V_XF_W] = min_xf(sclv_q[HCN_V_XF_LO +: HCN_V_XF_W],
            sclrv_q[HCN_V_XF_LO +: HCN_V_XF_W]); // R20 R6
        // npar3 ce field only present when the ce bit is set
        if (both_ce) msv_d[HCN_V_CE_LO +: HCN_V_CE_W] = sclv_q[HCN_V_CE_LO +: HCN_V_CE_W]; // R6
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_q <= HCN_CAP_RST;
        end else if (go_silent) begin
            ms_q <= HCN_CAP_RST; // R23
        end else if (in_hs && ev_sel) begin
            ms_q <= ms_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msv_q <= HCN_ZERO;
        end else if (go_silent) begin
            msv_q <= HCN_ZERO; // R23
        end else if (in_hs && ev_sel) begin
            msv_q <= msv_d;
        end
    end

    // =====================================================
    // apb read and outputs
    // =====================================================
    logic [31:0] rdat;
    always_comb begin
        rdat = HCN_ZERO;
        unique case (paddr)
            HCN_LCAP_OFS: begin
                rdat[HCN_CAPW-1:0] = lcap_q;
            end
            HCN_LVAL_OFS: begin
                rdat = lval_q;
            end
            HCN_RCAP_OFS: begin
                rdat[HCN_CAPW-1:0] = rcap_q;
            end
            HCN_RVAL_OFS: begin
                rdat = rval_q;
            end
            HCN_CL_OFS: begin
                rdat[HCN_CAPW-1:0] = scl_q;
            end
            HCN_MS_OFS: begin
                rdat[HCN_CAPW-1:0] = ms_q;
            end
            HCN_MSV_OFS: begin
                rdat = msv_q;
            end
            HCN_STAT_OFS: begin
                rdat[$bits(st_q)-1:0] = st_q;
            end
            default: begin
                rdat = hit ? HCN_ZERO : HCN_BAD;
            end
        endcase
    end

    // read data is taken in the setup cycle so it stands for the whole access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= HCN_ZERO;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rdat;
        end
    end

    // no wait states: every access phase lasts exactly one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_state <= HCN_SILENT1;
        end else begin
            hs_state <= st_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_quiet <= 1'b0;
        end else begin
            mode_quiet <= (st_q == HCN_QUIET); // R4
        end
    end

endmodule
`default_nettype wire

/* File: bench/hcn_top_assertions.sv */
// assertion checker for the handshake negotiation block
`default_nettype none
module hcn_assertions
    import hcn_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] hs_state,
    input wire logic mode_quiet
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic silent_wr;
    assign silent_wr = psel && penable && pwrite && paddr == HCN_CTRL_OFS && |pwdata[2:0];
    a_setup_answer: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (pready && paddr > 8'h20 |-> pslverr
        && (pwrite || prdata == HCN_BAD)) else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_silent_entry: assert property (silent_wr |=> ##1 hs_state == HCN_SILENT1)
        else $error("silent event did not reach silent state");
    a_quiet_flag: assert property (mode_quiet == (hs_state == HCN_QUIET))
        else $error("quiet flag disagrees with state");
    a_quiet_entry: assert property ($rose(mode_quiet) |-> $past(hs_state) == HCN_HSHAKE)
        else $error("quiet entered from wrong state");
    a_initrst_entry: assert property ($changed(hs_state) && hs_state == HCN_INITRST
        |-> $past(hs_state) == HCN_SILENT1) else $error("init reset from wrong state");
    a_hshake_entry: assert property ($changed(hs_state) && hs_state == HCN_HSHAKE
        |-> $past(hs_state) inside {HCN_SILENT1, HCN_INITRST}) else $error("bad handshake entry");
    a_quiet_hold: assert property (mode_quiet && !silent_wr && !$past(silent_wr)
        |=> mode_quiet) else $error("quiet state left without silent event");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error flag outside access phase");
    a_state_code: assert property (hs_state <= HCN_OTHER)
        else $error("illegal state code");
endmodule
bind hcn_top hcn_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hs_state(hs_state), .mode_quiet(mode_quiet));
`default_nettype wire

/* File: bench/hcn_far_model.sv */
// behavioural model of the remote modem's capability answer
`default_nettype none
module hcn_far_model
    import hcn_pkg::*;
(
    input wire logic [HCN_CAPW-1:0] want,
    input wire logic [3:0] xf_max,
    input wire logic [7:0] ce_len,
    output logic [HCN_CAPW-1:0] clr_cap,
    output logic [31:0] clr_val
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // answer content
    always_comb begin
        clr_cap = want;
        clr_cap[HCN_B_XFORM] = 1'b1;
        clr_val = HCN_ZERO;
        clr_val[3:0] = xf_max;
        // mandatory-only extension carries no length
        if (want[HCN_B_CE]) begin
            clr_val[15:8] = ce_len;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the handshake negotiation block
`default_nettype none
module tb_top
    import hcn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lv, msv, c;
    logic pready, pslverr, mode_quiet, pref, us, ds;
    logic [2:0] hs_state;
    logic [8:0] want = 9'h000, clr_cap, lc, cl, ms;
    logic [3:0] r_xf = 4'h0;
    logic [7:0] r_ce = 8'h00;
    logic [33:0] exp_q[$], note;
    int error_cnt = 0, num_checks = 0;
    always #12.5 pclk = ~pclk;
    hcn_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hs_state(hs_state), .mode_quiet(mode_quiet));
    hcn_far_model far (.want(want), .xf_max(r_xf), .ce_len(r_ce), .clr_cap(clr_cap),
        .clr_val(c));
    // ====
    // bus tasks and comparisons
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic err);
        exp_q.push_back({~w, err, e});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, HCN_ZERO, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, HCN_ZERO, e, 1'b0);
    endtask
    task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_err(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_hs(input logic [3:0] g, input logic [3:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk_err(pslverr, note[32]);
            if (note[33]) chk_data(prdata, note[31:0]);
            if (note[33] && paddr == HCN_STAT_OFS) begin
                chk_hs({mode_quiet, hs_state}, {note[2:0] == HCN_QUIET, note[2:0]});
            end
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end
    // ====
    // scenarios
    initial begin
        void'($urandom(32'hB002D288));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i <= 8; i++) rd(8'(4 * i), HCN_ZERO);
        xfer(1'b0, 8'h24, HCN_ZERO, HCN_BAD, 1'b1);
        xfer(1'b1, 8'h24, 32'hFFFF_FFFF, HCN_ZERO, 1'b1);
        wr(HCN_LCAP_OFS, 32'h1FF);
        wr(HCN_CTRL_OFS, 32'h20);
        wr(HCN_CL_OFS, 32'hFFFF_FFFF);
        rd(HCN_CL_OFS, HCN_ZERO);
        for (int i = 0; i < 24; i++) begin
            lc = 9'($urandom);
            lv = {16'h0, 8'($urandom), 4'h0, 4'($urandom)};
            want <= 9'($urandom);
            r_xf <= 4'($urandom);
            r_ce <= 8'($urandom);
            pref = 1'($urandom);
            wr(HCN_CTRL_OFS, 32'h1 << (i % 3));
            rd(HCN_STAT_OFS, 32'(HCN_SILENT1));
            rd(HCN_CL_OFS, HCN_ZERO);
            rd(HCN_MS_OFS, HCN_ZERO);
            if (i % 2 == 1) begin
                wr(HCN_CTRL_OFS, 32'h8);
                rd(HCN_STAT_OFS, 32'(HCN_INITRST));
            end
            wr(HCN_CTRL_OFS, 32'h10 | 32'(pref) << 9);
            rd(HCN_STAT_OFS, 32'(HCN_HSHAKE));
            wr(HCN_LCAP_OFS, 32'(lc));
            wr(HCN_LVAL_OFS, lv);
            rd(HCN_LVAL_OFS, lv);
            wr(HCN_RCAP_OFS, 32'(clr_cap));
            wr(HCN_RVAL_OFS, c);
            wr(HCN_CTRL_OFS, 32'h20 | 32'(pref) << 9);
            wr(HCN_CTRL_OFS, 32'h40 | 32'(pref) << 9);
            cl = lc | 9'h041;
            rd(HCN_CL_OFS, 32'(cl));
            us = cl[1] & clr_cap[1];
            ds = cl[2] & clr_cap[2];
            if (us & ds) begin
                us = pref;
                ds = ~pref;
            end
            ms = {1'b0, cl[7] & clr_cap[7], 1'b1, 2'b00, cl[3] & clr_cap[3], ds, us,
                cl[0] & clr_cap[0]};
            msv = {16'h0, ms[7] ? lv[15:8] : 8'h00, 4'h0,
                (lv[3:0] < c[3:0]) ? lv[3:0] : c[3:0]};
            wr(HCN_CTRL_OFS, 32'h80 | 32'(pref) << 9);
            rd(HCN_MS_OFS, 32'(ms));
            rd(HCN_MSV_OFS, msv);
            wr(HCN_CTRL_OFS, 32'h100 | 32'(pref) << 9);
            rd(HCN_STAT_OFS, 32'(ms[0] ? HCN_QUIET : HCN_OTHER));
        end
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
        finish_test();
    end
endmodule
`default_nettype wire
